// ==== pmcg_device.sv ====
// Power mode sequencer: sleep entry, wake, clock gating, brownout and watchdog lock
`timescale 1ns/1ns
`include "pmcg_map.svh"
module pmcg_device
	#(
	parameter int P = `PMCG_NUM_PERIPH,
	parameter int A = `PMCG_NUM_ANALOG,
	parameter int L = `PMCG_NUM_BOD_LEVELS
	)
	(
	input  wire logic              CORE_CLK_IN,
	input  wire logic              RESET_IN,
	input  wire logic              CE_IN,
	pmcg_if.dev                    LINK,
	input  wire logic [P-1:0]      PERIPH_IRQ_IN,
	input  wire logic [L-1:0]      VDD_BELOW_IN,
	output logic                   CPU_CLK_EN_OUT,
	output logic                   MAIN_CLK_EN_OUT,
	output logic [P-1:0]           PERIPH_CLK_EN_OUT,
	output logic [A-1:0]           ANALOG_PD_OUT,
	output logic                   FLASH_STANDBY_OUT,
	output logic                   STATE_HOLD_OUT,
	output logic                   LOW_OSC_EN_OUT,
	output logic                   HIGH_OSC_EN_OUT,
	output logic                   HIGH_OSC_96M_OUT,
	output logic                   RTC_OSC_EN_OUT,
	output logic                   WDT_OSC_EN_OUT,
	output pmcg_pkg::pmcg_clk_src_t MAIN_CLK_SEL_OUT,
	output logic                   BOD_RESET_OUT,
	output logic                   WDT_EN_OUT,
	output logic [7:0]             WDT_CFG_OUT
	);
	import pmcg_pkg::*;

	// Sequence: run, then sleep or deep, then one wake cycle back to run
	pmcg_state_t  state_q;
	pmcg_state_t  state_d;
	logic         wake_q;
	logic         bod_flag_q;
	logic [L-1:0] vdd_below;
	// Reset waits for the clock enable, so a frozen block keeps every flop
	wire          do_reset = RESET_IN & CE_IN;

	// Comparator outputs come from the analog domain, one bit per threshold level
	pmcg_sync3 #(.W(L)) u_bod_sync (
		.clk_in   (CORE_CLK_IN),
		.rst_in   (do_reset),
		.ce_in    (CE_IN),
		.async_in (VDD_BELOW_IN),
		.sync_out (vdd_below)
	);

	wire bod_int_hit  = vdd_below[LINK.bod_int_sel];
	wire bod_rst_hit  = vdd_below[LINK.bod_rst_sel];
	// A brownout seen in the clearing cycle wins over the clear
	wire bod_flag_d   = bod_int_hit | (bod_flag_q & ~LINK.bod_clear);
	wire bod_wake     = bod_flag_q & LINK.bod_int_en;
	// Only clocked peripherals can raise a wake while sleeping
	wire sleep_wake   = |(PERIPH_IRQ_IN & LINK.periph_run) | bod_wake;
	// In deep-sleep only peripherals kept clocked can still reach the core
	wire deep_wake    = |(PERIPH_IRQ_IN & LINK.periph_run & LINK.periph_keep) | bod_wake;
	// Requests count only from run; one arriving while asleep is dropped
	wire enter_sleep  = LINK.mode_req_valid && (LINK.mode_req == PMCG_REQ_SLEEP);
	wire enter_deep   = LINK.mode_req_valid && (LINK.mode_req == PMCG_REQ_DEEP);
	wire next_deep    = (state_d == PMCG_ST_DEEP);
	wire next_run     = (state_d == PMCG_ST_RUN);
	wire wake_d       = (state_d == PMCG_ST_WAKE);
	// Retention and pin hold cover both sleep depths
	wire next_hold    = (state_d == PMCG_ST_SLEEP) || next_deep;
	wire [P-1:0] keep_mask = next_deep ? LINK.periph_keep : {P{1'b1}};
	wire         cpu_clk_en_d  = next_run;
	wire         main_clk_en_d = ~next_deep | LINK.main_keep;
	wire [P-1:0] periph_en_d   = LINK.periph_run & keep_mask;
	wire [A-1:0] analog_pd_d   = next_deep ? ~LINK.analog_keep : '0;
	// One keep bit holds the whole free-running oscillator, both of its outputs
	wire         fro_on        = ~next_deep | LINK.osc_keep[0];
	wire         high_osc_on   = fro_on && (LINK.clk_sel == PMCG_SRC_HIGH_OSC);
	wire         rtc_osc_on    = LINK.rtc_osc_en & (~next_deep | LINK.osc_keep[1]);
	wire         wdt_osc_on    = LINK.wdt_osc_en & (~next_deep | LINK.osc_keep[2]);
	// A source change in mid-sleep would wake the core on a clock nobody checked
	wire         sel_load      = (state_q == PMCG_ST_RUN);
	wire         bod_reset_d   = LINK.bod_rst_en & bod_rst_hit;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			PMCG_ST_RUN:
			begin
				if (enter_sleep)
					state_d = PMCG_ST_SLEEP;
				else if (enter_deep)
					state_d = PMCG_ST_DEEP;
			end
			PMCG_ST_SLEEP:
			begin
				if (sleep_wake)
					state_d = PMCG_ST_WAKE;
			end
			PMCG_ST_DEEP:
			begin
				if (deep_wake)
					state_d = PMCG_ST_WAKE;
			end
			PMCG_ST_WAKE:
			begin
				// Clocks came back on entry; the processor follows one cycle later
				state_d = PMCG_ST_RUN;
			end
			default:
				state_d = PMCG_ST_RUN;
		endcase
	end

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (do_reset)
		begin
			state_q    <= PMCG_ST_RUN;
			wake_q     <= 1'b0;
			bod_flag_q <= 1'b0;
		end
		else if (CE_IN)
		begin
			state_q    <= state_d;
			// Marks the one cycle between restored clocks and a running core
			wake_q     <= wake_d;
			bod_flag_q <= bod_flag_d;
		end
	end

	// Processor clock returns one cycle after the gated clocks, so it never runs ungated
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (do_reset)
		begin
			CPU_CLK_EN_OUT    <= 1'b1;
			MAIN_CLK_EN_OUT   <= 1'b1;
			PERIPH_CLK_EN_OUT <= `PMCG_RST_PERIPH_RUN;
			ANALOG_PD_OUT     <= '0;
			FLASH_STANDBY_OUT <= 1'b0;
			STATE_HOLD_OUT    <= 1'b0;
		end
		else if (CE_IN)
		begin
			CPU_CLK_EN_OUT    <= cpu_clk_en_d;
			MAIN_CLK_EN_OUT   <= main_clk_en_d;
			PERIPH_CLK_EN_OUT <= periph_en_d;
			ANALOG_PD_OUT     <= analog_pd_d;
			FLASH_STANDBY_OUT <= next_deep;
			STATE_HOLD_OUT    <= next_hold;
		end
	end

	// Oscillator keep bits: free-running oscillator (low and high outputs), RTC oscillator, watchdog oscillator
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (do_reset)
		begin
			// Out of reset only the low oscillator runs, and the core runs from it
			LOW_OSC_EN_OUT   <= 1'b1;
			HIGH_OSC_EN_OUT  <= 1'b0;
			HIGH_OSC_96M_OUT <= 1'b0;
			RTC_OSC_EN_OUT   <= 1'b0;
			WDT_OSC_EN_OUT   <= 1'b0;
			MAIN_CLK_SEL_OUT <= PMCG_SRC_LOW_OSC;
		end
		else if (CE_IN)
		begin
			LOW_OSC_EN_OUT   <= fro_on;
			HIGH_OSC_EN_OUT  <= high_osc_on;
			HIGH_OSC_96M_OUT <= LINK.high_osc_96m;
			RTC_OSC_EN_OUT   <= rtc_osc_on;
			WDT_OSC_EN_OUT   <= wdt_osc_on;
			// Switching the source is only done while the processor runs
			if (sel_load)
				MAIN_CLK_SEL_OUT <= LINK.clk_sel;
		end
	end

	// Brownout reset request and watchdog lock
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (do_reset)
		begin
			BOD_RESET_OUT <= 1'b0;
			WDT_EN_OUT    <= 1'b0;
			WDT_CFG_OUT   <= `PMCG_RST_WDT_CFG;
		end
		else if (CE_IN)
		begin
			// A level, not a latch: reset stays asked for while the supply is low
			BOD_RESET_OUT <= bod_reset_d;
			// Once running the watchdog ignores every change; only reset clears it
			if (!WDT_EN_OUT)
			begin
				WDT_EN_OUT  <= LINK.wdt_en;
				WDT_CFG_OUT <= LINK.wdt_cfg;
			end
		end
	end

	// Status back to the controller, all straight from flops
	assign LINK.state      = state_q;
	assign LINK.cpu_run    = CPU_CLK_EN_OUT;
	assign LINK.wake       = wake_q;
	assign LINK.bod_flag   = bod_flag_q;
	assign LINK.wdt_locked = WDT_EN_OUT;
	assign LINK.clk_active = MAIN_CLK_SEL_OUT;
endmodule : pmcg_device

// ==== pmcg_host.sv ====
// Core-side controller: APB registers that order power modes and report status
`timescale 1ns/1ns
`include "pmcg_map.svh"
module pmcg_host
	#(
	parameter int P = `PMCG_NUM_PERIPH,
	parameter int A = `PMCG_NUM_ANALOG
	)
	(
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        CE_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	output logic             CORE_WAKE_OUT,
	pmcg_if.host             LINK
	);
	import pmcg_pkg::*;

	pmcg_mode_t    mode_q;
	logic          req_q;
	logic [P-1:0]  run_q;
	logic [P-1:0]  keep_q;
	logic [A-1:0]  analog_q;
	logic          main_keep_q;
	logic [2:0]    osc_keep_q;
	pmcg_clk_src_t sel_q;
	logic [6:3]    clock_q;
	logic [5:0]    bod_q;
	logic          clear_q;
	logic [8:0]    wdt_q;
	logic [31:0]   rd_data;
	// Reset waits for the clock enable, so a frozen block keeps every flop
	wire           do_reset = RESET_IN & CE_IN;

	wire access    = PSEL_IN & PENABLE_IN;
	wire wr_take   = access & PWRITE_IN & PREADY_OUT;
	wire hit_ctrl  = (PADDR_IN == `PMCG_OFS_CTRL);
	wire hit_run   = (PADDR_IN == `PMCG_OFS_PERIPH_RUN);
	wire hit_keep  = (PADDR_IN == `PMCG_OFS_PERIPH_KEEP);
	wire hit_akeep = (PADDR_IN == `PMCG_OFS_KEEP);
	wire hit_clock = (PADDR_IN == `PMCG_OFS_CLOCK);
	wire hit_bod   = (PADDR_IN == `PMCG_OFS_BOD);
	wire hit_wdt   = (PADDR_IN == `PMCG_OFS_WDT);
	wire hit_stat  = (PADDR_IN == `PMCG_OFS_STATUS);
	wire hit_any   = hit_ctrl | hit_run | hit_keep | hit_akeep | hit_clock | hit_bod
		| hit_wdt | hit_stat;
	wire [2:0] sel_raw = PWDATA_IN[2:0];
	// Enable bits written in the same word count as already set
	wire rtc_ok = PWDATA_IN[`PMCG_CLOCK_RTC_EN];
	wire wdt_ok = PWDATA_IN[`PMCG_CLOCK_WDT_EN];
	wire pin_ok = PWDATA_IN[`PMCG_CLOCK_PIN_EN];
	wire sel_ok = (sel_raw == 3'h2) ? rtc_ok :
		(sel_raw == 3'h3) ? wdt_ok :
		(sel_raw == 3'h4) ? pin_ok : (sel_raw <= 3'h5);

	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (hit_ctrl)
			rd_data[1:0] = mode_q;
		else if (hit_run)
			rd_data[P-1:0] = run_q;
		else if (hit_keep)
			rd_data[P-1:0] = keep_q;
		else if (hit_akeep)
			rd_data[11:0] = {osc_keep_q, main_keep_q, {(8-A){1'b0}}, analog_q};
		else if (hit_clock)
			rd_data[6:0] = {clock_q, sel_q};
		else if (hit_bod)
			rd_data[5:0] = bod_q;
		else if (hit_wdt)
			rd_data[8:0] = wdt_q;
		else if (hit_stat)
			rd_data[7:0] = {LINK.clk_active, LINK.wdt_locked, LINK.bod_flag, LINK.cpu_run,
				LINK.state};
	end

	// One wait state: every access answers in its second access cycle
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (do_reset)
		begin
			PREADY_OUT    <= 1'b0;
			PRDATA_OUT    <= 32'h0000_0000;
			PSLVERR_OUT   <= 1'b0;
			CORE_WAKE_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			PREADY_OUT    <= access & ~PREADY_OUT;
			PRDATA_OUT    <= (access & ~PREADY_OUT & ~PWRITE_IN) ? rd_data : 32'h0000_0000;
			PSLVERR_OUT   <= access & ~PREADY_OUT & ~hit_any;
			CORE_WAKE_OUT <= LINK.wake;
		end
	end

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (do_reset)
		begin
			mode_q      <= PMCG_REQ_RUN;
			req_q       <= 1'b0;
			run_q       <= `PMCG_RST_PERIPH_RUN;
			keep_q      <= `PMCG_RST_PERIPH_KEEP;
			analog_q    <= `PMCG_RST_ANALOG_KEEP;
			main_keep_q <= 1'b0;
			osc_keep_q  <= 3'h0;
			sel_q       <= PMCG_SRC_LOW_OSC;
			clock_q     <= 4'h0;
			bod_q       <= 6'h00;
			clear_q     <= 1'b0;
			wdt_q       <= 9'h000;
		end
		else if (CE_IN)
		begin
			req_q   <= wr_take & hit_ctrl & (PWDATA_IN[1:0] != 2'h0);
			clear_q <= wr_take & hit_bod & PWDATA_IN[`PMCG_BOD_CLEAR];
			if (wr_take & hit_ctrl)
				mode_q <= pmcg_mode_t'(PWDATA_IN[1:0]);
			if (wr_take & hit_run)
				run_q <= PWDATA_IN[P-1:0];
			if (wr_take & hit_keep)
				keep_q <= PWDATA_IN[P-1:0];
			if (wr_take & hit_akeep)
			begin
				analog_q    <= PWDATA_IN[A-1:0];
				main_keep_q <= PWDATA_IN[`PMCG_KEEP_MAIN];
				osc_keep_q  <= PWDATA_IN[`PMCG_KEEP_OSC_LO +: 3];
			end
			if (wr_take & hit_clock)
			begin
				clock_q <= PWDATA_IN[6:3];
				if (sel_ok)
					sel_q <= pmcg_clk_src_t'(sel_raw);
			end
			if (wr_take & hit_bod)
				bod_q <= PWDATA_IN[5:0];
			// Once the watchdog runs its register stays frozen
			if (wr_take & hit_wdt & ~LINK.wdt_locked)
				wdt_q <= PWDATA_IN[8:0];
		end
	end

	assign LINK.mode_req       = mode_q;
	assign LINK.mode_req_valid = req_q;
	assign LINK.periph_run     = run_q;
	assign LINK.periph_keep    = keep_q;
	assign LINK.analog_keep    = analog_q;
	assign LINK.main_keep      = main_keep_q;
	assign LINK.osc_keep       = osc_keep_q;
	assign LINK.clk_sel        = sel_q;
	assign LINK.high_osc_96m   = clock_q[`PMCG_CLOCK_HF96];
	assign LINK.rtc_osc_en     = clock_q[`PMCG_CLOCK_RTC_EN];
	assign LINK.wdt_osc_en     = clock_q[`PMCG_CLOCK_WDT_EN];
	assign LINK.bod_int_sel    = bod_q[1:0];
	assign LINK.bod_rst_sel    = bod_q[3:2];
	assign LINK.bod_int_en     = bod_q[`PMCG_BOD_INT_EN];
	assign LINK.bod_rst_en     = bod_q[`PMCG_BOD_RST_EN];
	assign LINK.bod_clear      = clear_q;
	assign LINK.wdt_en         = wdt_q[`PMCG_WDT_EN];
	assign LINK.wdt_cfg        = wdt_q[7:0];
endmodule : pmcg_host

// ==== pmcg_if.sv ====
// Link between the core-side controller and the power mode sequencer
`timescale 1ns/1ns
interface pmcg_if
	#(parameter int P = 10, parameter int A = 4);
	import pmcg_pkg::*;
	pmcg_mode_t    mode_req;
	logic          mode_req_valid;
	logic [P-1:0]  periph_run;
	logic [P-1:0]  periph_keep;
	logic [A-1:0]  analog_keep;
	logic          main_keep;
	logic [2:0]    osc_keep;
	pmcg_clk_src_t clk_sel;
	logic          high_osc_96m;
	logic          rtc_osc_en;
	logic          wdt_osc_en;
	logic [1:0]    bod_int_sel;
	logic [1:0]    bod_rst_sel;
	logic          bod_int_en;
	logic          bod_rst_en;
	logic          bod_clear;
	logic          wdt_en;
	logic [7:0]    wdt_cfg;
	pmcg_state_t   state;
	logic          cpu_run;
	logic          wake;
	logic          bod_flag;
	logic          wdt_locked;
	pmcg_clk_src_t clk_active;

	modport host (output mode_req, mode_req_valid, periph_run, periph_keep, analog_keep,
		main_keep, osc_keep, clk_sel, high_osc_96m, rtc_osc_en, wdt_osc_en, bod_int_sel,
		bod_rst_sel, bod_int_en, bod_rst_en, bod_clear, wdt_en, wdt_cfg,
		input state, cpu_run, wake, bod_flag, wdt_locked, clk_active);
	modport dev (input mode_req, mode_req_valid, periph_run, periph_keep, analog_keep,
		main_keep, osc_keep, clk_sel, high_osc_96m, rtc_osc_en, wdt_osc_en, bod_int_sel,
		bod_rst_sel, bod_int_en, bod_rst_en, bod_clear, wdt_en, wdt_cfg,
		output state, cpu_run, wake, bod_flag, wdt_locked, clk_active);
endinterface : pmcg_if

// ==== pmcg_link_monitor.sv ====
// Concurrent checks on the link between the core-side controller and the sequencer
`timescale 1ns/1ns
module pmcg_link_monitor
	(
	input wire logic                 CORE_CLK_IN,
	input wire logic                 RESET_IN,
	input wire pmcg_pkg::pmcg_mode_t mode_req,
	input wire logic                 mode_req_valid,
	input wire pmcg_pkg::pmcg_state_t state,
	input wire logic                 cpu_run,
	input wire logic                 wake,
	input wire logic                 bod_flag,
	input wire logic                 bod_clear,
	input wire logic                 wdt_locked,
	input wire pmcg_pkg::pmcg_clk_src_t clk_active
	);
	import pmcg_pkg::*;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RESET_IN);
	a_sleep_entry: assert property (
		mode_req_valid && mode_req == PMCG_REQ_SLEEP && state == PMCG_ST_RUN
		|=> state == PMCG_ST_SLEEP) else $error("sleep request not taken");
	a_deep_entry: assert property (
		mode_req_valid && mode_req == PMCG_REQ_DEEP && state == PMCG_ST_RUN
		|=> state == PMCG_ST_DEEP) else $error("deep request not taken");
	a_cpu_gate: assert property (
		cpu_run == (state == PMCG_ST_RUN)) else $error("processor clock out of step");
	a_wake_resume: assert property (
		wake |-> state == PMCG_ST_WAKE ##1 (state == PMCG_ST_RUN && cpu_run))
		else $error("wake did not resume");
	a_wake_origin: assert property (
		state == PMCG_ST_WAKE |-> $past(state) inside {PMCG_ST_SLEEP, PMCG_ST_DEEP})
		else $error("wake state without low power mode");
	a_wdt_sticky: assert property (
		wdt_locked |=> wdt_locked) else $error("watchdog lock dropped");
	a_bod_hold: assert property (
		bod_flag && !bod_clear |=> bod_flag) else $error("brownout flag lost");
	a_sel_frozen: assert property (
		state != PMCG_ST_RUN && $past(state) != PMCG_ST_RUN |-> $stable(clk_active))
		else $error("clock select moved while asleep");
endmodule : pmcg_link_monitor

// ==== pmcg_map.svh ====
// Register offsets, field positions, reset values and sizes for the power mode controller
//
// How it works
// - Sleep stops processor clock until reset or interrupt
// - Clocked peripherals run and wake from sleep
// - Sleep states keep state and hold pins
// - Deep-sleep stops processor clock like sleep
// - Deep-sleep powers down analog except kept ones
// - Deep-sleep gates main, peripheral clocks unless kept
// - Flash goes to standby in deep-sleep
// - Listed peripherals may stay running in deep-sleep
// - Three oscillators may stay running in deep-sleep
// - Brownout below level sets pollable, interruptible flag
// - Separate brownout reset and interrupt thresholds
// - Enabled watchdog configuration locked until reset
// - Reset runs system from low internal oscillator
// - High oscillator selectable between 96 and 48 MHz
// - Unused clock mux should select the none source
// - Main clock drives processor and bus
// - RTC oscillator enabled before slow clock use
// - Watchdog oscillator enabled before its use
// - Clock input pin routed before its use
`ifndef PMCG_MAP_SVH
`define PMCG_MAP_SVH

`define PMCG_NUM_PERIPH      10
`define PMCG_NUM_ANALOG      4
`define PMCG_NUM_BOD_LEVELS  4

`define PMCG_OFS_CTRL        8'h00
`define PMCG_OFS_PERIPH_RUN  8'h04
`define PMCG_OFS_PERIPH_KEEP 8'h08
`define PMCG_OFS_KEEP        8'h0c
`define PMCG_OFS_CLOCK       8'h10
`define PMCG_OFS_BOD         8'h14
`define PMCG_OFS_WDT         8'h18
`define PMCG_OFS_STATUS      8'h1c

`define PMCG_KEEP_MAIN       8
`define PMCG_KEEP_OSC_LO     9
`define PMCG_CLOCK_HF96      3
`define PMCG_CLOCK_RTC_EN    4
`define PMCG_CLOCK_WDT_EN    5
`define PMCG_CLOCK_PIN_EN    6
`define PMCG_BOD_INT_EN      4
`define PMCG_BOD_RST_EN      5
`define PMCG_BOD_CLEAR       8
`define PMCG_WDT_EN          8

`define PMCG_RST_PERIPH_RUN  10'h3ff
`define PMCG_RST_PERIPH_KEEP 10'h000
`define PMCG_RST_ANALOG_KEEP 4'h0
`define PMCG_RST_WDT_CFG     8'h00

`endif

// ==== pmcg_pkg.sv ====
// Types shared by both ends of the power mode controller
package pmcg_pkg;
	typedef enum logic [1:0] {PMCG_REQ_RUN, PMCG_REQ_SLEEP, PMCG_REQ_DEEP} pmcg_mode_t;
	typedef enum logic [1:0] {PMCG_ST_RUN, PMCG_ST_SLEEP, PMCG_ST_DEEP, PMCG_ST_WAKE} pmcg_state_t;
	typedef enum logic [2:0] {PMCG_SRC_LOW_OSC, PMCG_SRC_HIGH_OSC, PMCG_SRC_RTC_SLOW,
		PMCG_SRC_WDT_OSC, PMCG_SRC_CLK_IN, PMCG_SRC_NONE} pmcg_clk_src_t;
endpackage : pmcg_pkg

// ==== pmcg_sync3.sv ====
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ns
module pmcg_sync3
	#(parameter int W = 4)
	(
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         ce_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
	);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	wire  [W-1:0] agree = ~(s2_q ^ s3_q);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s1_q     <= '0;
			s2_q     <= '0;
			s3_q     <= '0;
			sync_out <= '0;
		end
		else if (ce_in)
		begin
			s1_q     <= async_in;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			sync_out <= (agree & s3_q) | (~agree & sync_out);
		end
	end
endmodule : pmcg_sync3

// ==== power_mode_clock_gating_bench.sv ====
// Self-checking bench for both ends of the power mode controller
`timescale 1ns/1ns
module power_mode_clock_gating_bench;
	import pmcg_pkg::*;
	logic clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, err;
	logic [7:0] paddr = 8'h00, wdt_cfg;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, core_wake, cpu_en, main_en, flash_sb, hold, losc, hosc, h96;
	logic rtc_en, wdt_osc, bod_rst, wdt_on;
	logic [9:0] irq = 10'h000, periph_en, r, k;
	logic [3:0] vdd = 4'h0, apd;
	logic [11:0] kp;
	pmcg_clk_src_t sel;
	integer seed = 32'h0f4bcee7;
	integer mismatches = 0, tests_run = 0, i;

	pmcg_if #(.P(10), .A(4)) link ();
	pmcg_host u_pmcg_host (.CORE_CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.CORE_WAKE_OUT(core_wake), .LINK(link));
	pmcg_device u_pmcg_device (.CORE_CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .LINK(link),
		.PERIPH_IRQ_IN(irq), .VDD_BELOW_IN(vdd), .CPU_CLK_EN_OUT(cpu_en),
		.MAIN_CLK_EN_OUT(main_en), .PERIPH_CLK_EN_OUT(periph_en), .ANALOG_PD_OUT(apd),
		.FLASH_STANDBY_OUT(flash_sb), .STATE_HOLD_OUT(hold), .LOW_OSC_EN_OUT(losc),
		.HIGH_OSC_EN_OUT(hosc), .HIGH_OSC_96M_OUT(h96), .RTC_OSC_EN_OUT(rtc_en),
		.WDT_OSC_EN_OUT(wdt_osc), .MAIN_CLK_SEL_OUT(sel), .BOD_RESET_OUT(bod_rst),
		.WDT_EN_OUT(wdt_on), .WDT_CFG_OUT(wdt_cfg));
	pmcg_link_monitor u_pmcg_link_monitor (.CORE_CLK_IN(clk), .RESET_IN(rst),
		.mode_req(link.mode_req), .mode_req_valid(link.mode_req_valid), .state(link.state),
		.cpu_run(link.cpu_run), .wake(link.wake), .bod_flag(link.bod_flag),
		.bod_clear(link.bod_clear), .wdt_locked(link.wdt_locked),
		.clk_active(link.clk_active));

	initial
	begin
		forever #20 clk = ~clk;
	end

	task automatic test_done;
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// Expected deep-sleep gating, worked out from the masks software wrote
	function automatic logic [31:0] deep_periph(input logic [9:0] run, input logic [9:0] keep);
		return {22'h0, run & keep};
	endfunction : deep_periph

	function automatic logic [31:0] deep_analog(input logic [11:0] keep);
		return {28'h0, ~keep[3:0]};
	endfunction : deep_analog

	// An idle cycle leads each transfer so a release and a new setup never share an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			test_done;
		end
	endtask : apb

	task automatic wait_wake;
		int t;
		t = 0;
		while (core_wake !== 1'b1 && t < 30)
		begin
			@(posedge clk);
			t++;
		end
		if (core_wake !== 1'b1)
		begin
			mismatches++;
			test_done;
		end
	endtask : wait_wake

	initial
	begin
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		chk("cpu clock", 1, cpu_en);
		chk("main select", PMCG_SRC_LOW_OSC, sel);
		chk("low osc", 1, losc);
		apb(0, 8'h04, 0);
		chk("run mask", 32'h3ff, rd);
		apb(0, 8'h20, 0);
		chk("unmapped slverr", 1, err);
		for (i = 0; i < 6; i++)
		begin
			apb(1, 8'h10, {25'h0, 3'h7, i[0], i[2:0]});
			cyc(3);
			chk("main select", i, sel);
			chk("high osc enable", i == 1, hosc);
			chk("high osc 96m", i[0], h96);
		end
		// Each source offered with only its own prerequisite missing must be refused
		for (i = 2; i < 5; i++)
		begin
			apb(1, 8'h10, (32'h70 ^ (32'h1 << (i + 2))) | i);
			cyc(3);
			chk("select refused", PMCG_SRC_NONE, sel);
		end
		// High oscillator as main source, so its deep-sleep keep bit shows
		apb(1, 8'h10, 32'h31);
		apb(1, 8'h04, 32'h3fe);
		apb(1, 8'h00, 32'h1);
		cyc(3);
		chk("sleep cpu", 0, cpu_en);
		chk("sleep hold", 1, hold);
		chk("sleep main", 1, main_en);
		chk("sleep periph", 32'h3fe, periph_en);
		irq <= 10'h001;
		cyc(4);
		chk("unclocked irq", 0, cpu_en);
		// A wake seen while the enable is low must wait for the enable
		ce <= 1'b0;
		irq <= 10'h003;
		cyc(4);
		chk("frozen cpu", 0, cpu_en);
		chk("frozen hold", 1, hold);
		ce <= 1'b1;
		wait_wake;
		irq <= 10'h000;
		cyc(1);
		chk("sleep wake cpu", 1, cpu_en);
		chk("wake hold", 0, hold);
		for (i = 0; i < 3; i++)
		begin
			r = 10'($random(seed)) | 10'h1;
			k = 10'($random(seed)) | 10'h1;
			kp = 12'($random(seed)) & 12'hf0f;
			apb(1, 8'h04, {22'h0, r});
			apb(1, 8'h08, {22'h0, k});
			apb(1, 8'h0c, {20'h0, kp});
			apb(1, 8'h00, 32'h2);
			cyc(3);
			chk("deep cpu", 0, cpu_en);
			chk("deep main", kp[8], main_en);
			chk("deep periph", deep_periph(r, k), periph_en);
			chk("deep analog", deep_analog(kp), apd);
			chk("flash standby", 1, flash_sb);
			chk("deep hold", 1, hold);
			chk("low osc kept", kp[9], losc);
			chk("high osc kept", kp[9], hosc);
			chk("rtc osc kept", kp[10], rtc_en);
			chk("wdt osc kept", kp[11], wdt_osc);
			irq <= ~(r & k);
			cyc(4);
			chk("deep stays", 0, cpu_en);
			irq <= r & k;
			wait_wake;
			irq <= 10'h000;
			cyc(1);
			chk("wake cpu", 1, cpu_en);
			chk("wake main", 1, main_en);
			chk("wake periph", r, periph_en);
			chk("wake analog", 0, apd);
			chk("wake flash", 0, flash_sb);
			chk("wake rtc osc", 1, rtc_en);
			chk("wake high osc", 1, hosc);
		end
		apb(1, 8'h14, 32'h39);
		vdd <= 4'h2;
		cyc(6);
		apb(0, 8'h1c, 0);
		chk("bod flag", 1, rd[3]);
		chk("bod reset", 0, bod_rst);
		apb(1, 8'h14, 32'h139);
		cyc(2);
		apb(0, 8'h1c, 0);
		chk("bod set wins", 1, rd[3]);
		vdd <= 4'h0;
		cyc(6);
		apb(1, 8'h14, 32'h139);
		cyc(2);
		apb(0, 8'h1c, 0);
		chk("bod cleared", 0, rd[3]);
		vdd <= 4'h4;
		cyc(6);
		chk("bod reset", 1, bod_rst);
		apb(0, 8'h1c, 0);
		chk("bod int level", 0, rd[3]);
		vdd <= 4'h0;
		apb(1, 8'h18, 32'h1a5);
		cyc(3);
		chk("wdt enable", 1, wdt_on);
		apb(1, 8'h18, 32'h03c);
		cyc(3);
		chk("wdt cfg locked", 32'ha5, wdt_cfg);
		chk("wdt still on", 1, wdt_on);
		apb(0, 8'h1c, 0);
		chk("wdt lock status", 1, rd[4]);
		rst <= 1'b1;
		cyc(4);
		rst <= 1'b0;
		cyc(1);
		chk("wdt after reset", 0, wdt_on);
		chk("select after reset", PMCG_SRC_LOW_OSC, sel);
		test_done;
	end
endmodule : power_mode_clock_gating_bench
